// *** verilog/mac_regs_pkg.sv ***
package mac_regs_pkg;

    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int BE_W   = 4;
    localparam int LANE_W = 8;
    localparam int IRQ_W  = 2;

    // Byte addresses of the word registers
    localparam logic [ADDR_W-1:0] OFF_RAW       = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MASKED    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_EN_SET    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EN_CLEAR  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FILTER    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVENT     = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVENT_EN  = 8'h18;

    // Interrupt source bit positions
    localparam int BIT_STATS = 0;
    localparam int BIT_HOST  = 1;

    // Reset values and writable masks
    localparam logic [IRQ_W-1:0]  IRQ_RESET      = 2'h0;
    localparam logic [DATA_W-1:0] FILTER_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] FILTER_RW_MASK = 32'h71e7_2727;
    localparam logic [DATA_W-1:0] WORD_ZERO      = 32'h0000_0000;

    // Two interrupt sources, host error above statistics
    typedef struct packed {
        logic host_error;
        logic stats;
    } irq_bits_t;

    // Receive frame filter enable word, bit 31 first
    typedef struct packed {
        logic       rsvd31;
        logic       keep_rx_crc;
        logic       rx_qos_on;
        logic       single_buffer_rx;
        logic [2:0] rsvd27;
        logic       copy_control_frames;
        logic       copy_short_frames;
        logic       copy_error_frames;
        logic       copy_all_frames;
        logic [1:0] rsvd20;
        logic [2:0] promiscuous_channel_sel;
        logic [1:0] rsvd15;
        logic       broadcast_accept;
        logic [1:0] rsvd12;
        logic [2:0] broadcast_channel_sel;
        logic [1:0] rsvd7;
        logic       multicast_accept;
        logic [1:0] rsvd4;
        logic [2:0] multicast_channel_sel;
    } rx_filter_t;

endpackage

// *** verilog/enable_bits.sv ***
`timescale 1ns/1ps
module enable_bits #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // One-cycle set and clear strobes
    input  wire logic [WIDTH-1:0] set_bits,
    input  wire logic [WIDTH-1:0] clear_bits,
    // Current enables
    output logic      [WIDTH-1:0] bits
);

    logic [WIDTH-1:0] next_bits;

    // Set and clear come from different registers, never together
    always_comb begin
        next_bits = (bits | set_bits) & ~clear_bits;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits <= '0;
        end else begin
            bits <= next_bits;
        end
    end

endmodule

// *** verilog/sticky_flags.sv ***
`timescale 1ns/1ps
module sticky_flags #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Event pulses and clear strobes
    input  wire logic [WIDTH-1:0] set_bits,
    input  wire logic [WIDTH-1:0] clear_bits,
    // Held flags
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // Set wins so an event in the clearing cycle is kept
    always_comb begin
        next_flags = (flags & ~clear_bits) | set_bits;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule

// *** verilog/mac_irq_and_rx_filter_regs.sv ***
// Contract
// - Raw status bit 1 reads host error pending, mask ignored.
// - Raw status bit 0 reads statistics pending, mask ignored.
// - Masked status bit 1 reads host error pending gated by its enable.
// - Masked status bit 0 reads statistics pending gated by its enable.
// - Set register bit 1 written 1 enables host error; 0 no effect; reads enable.
// - Set register bit 0 written 1 enables statistics; 0 no effect.
// - Clear register bit 1 written 1 disables host error; 0 no effect; reads enable.
// - Clear register bit 0 written 1 disables statistics; 0 no effect.
// - Filter register fields read/write, reset zero, at their fixed positions.
// - Keep-CRC bit selects CRC kept and counted, or dropped.
// - Single-buffer bit puts each frame in one buffer, length up to 65535.
// - Copy-control bit passes control frames to memory, else filtered.
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module mac_irq_and_rx_filter_regs (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // Avalon-MM slave
    input  wire logic [mac_regs_pkg::ADDR_W-1:0]   address,
    input  wire logic                              read,
    input  wire logic                              write,
    input  wire logic [mac_regs_pkg::DATA_W-1:0]   writedata,
    input  wire logic [mac_regs_pkg::BE_W-1:0]     byteenable,
    output logic      [mac_regs_pkg::DATA_W-1:0]   readdata,
    output logic                                   waitrequest,
    // Pending conditions from the MAC core
    input  wire logic                              host_error_pending,
    input  wire logic                              stats_pending,
    // Interrupt outputs
    output logic                                   mac_misc_irq,
    output logic                                   event_irq,
    // Receive filter configuration
    output mac_regs_pkg::rx_filter_t               rx_filter
);

    // Raw and gated sources
    mac_regs_pkg::irq_bits_t raw;
    mac_regs_pkg::irq_bits_t irq_enable;
    mac_regs_pkg::irq_bits_t masked;
    mac_regs_pkg::irq_bits_t raw_q;
    mac_regs_pkg::irq_bits_t next_raw_q;
    mac_regs_pkg::irq_bits_t rise;

    // Event status and its mask
    mac_regs_pkg::irq_bits_t event_status;
    mac_regs_pkg::irq_bits_t event_enable;
    mac_regs_pkg::irq_bits_t next_event_enable;
    mac_regs_pkg::irq_bits_t event_clear;

    // Bus decode
    logic                                  req;
    logic                                  wr_go;
    logic                                  rd_go;
    logic                                  hit_en_set;
    logic                                  hit_en_clear;
    logic                                  hit_filter;
    logic                                  hit_event;
    logic                                  hit_event_en;
    logic                                  wr_en_set;
    logic                                  wr_en_clear;
    logic                                  wr_filter;
    logic                                  wr_event_en;
    logic                                  rd_event;
    logic [mac_regs_pkg::DATA_W-1:0]       lane_mask;
    logic [mac_regs_pkg::DATA_W-1:0]       wr_bits;
    logic [mac_regs_pkg::DATA_W-1:0]       rd_mux;
    logic [mac_regs_pkg::DATA_W-1:0]       next_readdata;
    logic                                  next_waitrequest;
    mac_regs_pkg::irq_bits_t               en_set;
    mac_regs_pkg::irq_bits_t               en_clear;

    // Filter and interrupt output next values
    mac_regs_pkg::rx_filter_t              next_rx_filter;
    logic [mac_regs_pkg::DATA_W-1:0]       filter_keep;
    mac_regs_pkg::rx_filter_t              filter_view;
    logic                                  next_mac_misc_irq;
    logic                                  next_event_irq;

    // Sources come from the MAC core on this clock, no synchroniser
    always_comb begin
        raw.host_error = host_error_pending;
        raw.stats      = stats_pending;
    end

    // Masked view is combinational so it tracks the raw level
    always_comb begin
        masked.host_error = raw.host_error & irq_enable.host_error;
        masked.stats      = raw.stats & irq_enable.stats;
    end

    // Edge detect feeds the sticky event flags
    always_comb begin
        next_raw_q = raw;
        rise       = raw & ~raw_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_q <= mac_regs_pkg::IRQ_RESET;
        end else begin
            raw_q <= next_raw_q;
        end
    end

    // Request taken at the edge where waitrequest is low
    always_comb begin
        req   = read | write;
        wr_go = write & ~waitrequest;
        rd_go = read & ~waitrequest;
    end

    // One comparator per strobed register, used by the write and event-read strobes; the read mux decodes address itself
    always_comb begin
        hit_en_set   = address == mac_regs_pkg::OFF_EN_SET;
        hit_en_clear = address == mac_regs_pkg::OFF_EN_CLEAR;
        hit_filter   = address == mac_regs_pkg::OFF_FILTER;
        hit_event    = address == mac_regs_pkg::OFF_EVENT;
        hit_event_en = address == mac_regs_pkg::OFF_EVENT_EN;
    end

    // Strobes last only the committing cycle, so side effects happen once
    always_comb begin
        wr_en_set   = wr_go & hit_en_set;
        wr_en_clear = wr_go & hit_en_clear;
        wr_filter   = wr_go & hit_filter;
        wr_event_en = wr_go & hit_event_en;
        rd_event    = rd_go & hit_event;
    end

    // Byte enables expanded to a bit mask
    always_comb begin
        for (int i = 0; i < mac_regs_pkg::BE_W; i++) begin
            lane_mask[i*mac_regs_pkg::LANE_W +: mac_regs_pkg::LANE_W] =
                {mac_regs_pkg::LANE_W{byteenable[i]}};
        end
        wr_bits = writedata & lane_mask;
    end

    // Enable set and clear strobes
    always_comb begin
        en_set   = mac_regs_pkg::IRQ_RESET;
        en_clear = mac_regs_pkg::IRQ_RESET;
        if (wr_en_set) begin
            en_set.host_error = wr_bits[mac_regs_pkg::BIT_HOST];
            en_set.stats      = wr_bits[mac_regs_pkg::BIT_STATS];
        end
        if (wr_en_clear) begin
            en_clear.host_error = wr_bits[mac_regs_pkg::BIT_HOST];
            en_clear.stats      = wr_bits[mac_regs_pkg::BIT_STATS];
        end
    end

    // Enables reset to disabled
    enable_bits #(
        .WIDTH      (mac_regs_pkg::IRQ_W)
    ) u_enable (
        .clk        (clk),
        .rst_n      (rst_n),
        .set_bits   (en_set),
        .clear_bits (en_clear),
        .bits       (irq_enable)
    );

    // Clearing only what was returned keeps events that arrive meanwhile
    always_comb begin
        event_clear = mac_regs_pkg::IRQ_RESET;
        if (rd_event) begin
            event_clear = readdata[mac_regs_pkg::IRQ_W-1:0];
        end
    end

    sticky_flags #(
        .WIDTH      (mac_regs_pkg::IRQ_W)
    ) u_events (
        .clk        (clk),
        .rst_n      (rst_n),
        .set_bits   (rise),
        .clear_bits (event_clear),
        .flags      (event_status)
    );

    // Event mask is plain read/write
    always_comb begin
        next_event_enable = event_enable;
        if (wr_event_en) begin
            next_event_enable = wr_bits[mac_regs_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_enable <= mac_regs_pkg::IRQ_RESET;
        end else begin
            event_enable <= next_event_enable;
        end
    end

    // Filter word: only documented fields take writes
    always_comb begin
        filter_keep    = ~(mac_regs_pkg::FILTER_RW_MASK & lane_mask);
        next_rx_filter = rx_filter;
        if (wr_filter) begin
            next_rx_filter = mac_regs_pkg::rx_filter_t'(
                (rx_filter & filter_keep) |
                (wr_bits & mac_regs_pkg::FILTER_RW_MASK));
        end
    end

    // Datapath reads keep_rx_crc, single_buffer_rx, copy_control_frames
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_filter <= mac_regs_pkg::rx_filter_t'(mac_regs_pkg::FILTER_RESET);
        end else begin
            rx_filter <= next_rx_filter;
        end
    end

    // Read view rebuilt field by field, so reserved bits read zero by construction
    always_comb begin
        filter_view                         = mac_regs_pkg::rx_filter_t'(mac_regs_pkg::WORD_ZERO);
        filter_view.keep_rx_crc             = rx_filter.keep_rx_crc;
        filter_view.rx_qos_on               = rx_filter.rx_qos_on;
        filter_view.single_buffer_rx        = rx_filter.single_buffer_rx;
        filter_view.copy_control_frames     = rx_filter.copy_control_frames;
        filter_view.copy_short_frames       = rx_filter.copy_short_frames;
        filter_view.copy_error_frames       = rx_filter.copy_error_frames;
        filter_view.copy_all_frames         = rx_filter.copy_all_frames;
        filter_view.promiscuous_channel_sel = rx_filter.promiscuous_channel_sel;
        filter_view.broadcast_accept        = rx_filter.broadcast_accept;
        filter_view.broadcast_channel_sel   = rx_filter.broadcast_channel_sel;
        filter_view.multicast_accept        = rx_filter.multicast_accept;
        filter_view.multicast_channel_sel   = rx_filter.multicast_channel_sel;
    end

    // Read mux, unused bits stay zero
    always_comb begin
        rd_mux = mac_regs_pkg::WORD_ZERO;
        case (address)
            mac_regs_pkg::OFF_RAW: begin
                rd_mux[mac_regs_pkg::BIT_HOST]  = raw.host_error;
                rd_mux[mac_regs_pkg::BIT_STATS] = raw.stats;
            end
            mac_regs_pkg::OFF_MASKED: begin
                rd_mux[mac_regs_pkg::BIT_HOST]  = masked.host_error;
                rd_mux[mac_regs_pkg::BIT_STATS] = masked.stats;
            end
            mac_regs_pkg::OFF_EN_SET: begin
                rd_mux[mac_regs_pkg::IRQ_W-1:0] = irq_enable;
            end
            mac_regs_pkg::OFF_EN_CLEAR: begin
                rd_mux[mac_regs_pkg::IRQ_W-1:0] = irq_enable;
            end
            mac_regs_pkg::OFF_FILTER: begin
                rd_mux = filter_view;
            end
            mac_regs_pkg::OFF_EVENT: begin
                rd_mux[mac_regs_pkg::IRQ_W-1:0] = event_status;
            end
            mac_regs_pkg::OFF_EVENT_EN: begin
                rd_mux[mac_regs_pkg::IRQ_W-1:0] = event_enable;
            end
            default: begin
                rd_mux = mac_regs_pkg::WORD_ZERO;
            end
        endcase
    end

    // One wait cycle on every access: data is registered, a timing trade
    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata    = readdata;
        if (req && waitrequest) begin
            next_waitrequest = 1'b0;
            if (read) begin
                next_readdata = rd_mux;
            end else begin
                next_readdata = mac_regs_pkg::WORD_ZERO;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= mac_regs_pkg::WORD_ZERO;
        end else begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // Interrupt outputs, registered: mac_misc_irq lags its source by one edge, event_irq by two
    always_comb begin
        next_mac_misc_irq = |masked;
        next_event_irq    = |(event_status & event_enable);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_misc_irq <= 1'b0;
            event_irq    <= 1'b0;
        end else begin
            mac_misc_irq <= next_mac_misc_irq;
            event_irq    <= next_event_irq;
        end
    end

endmodule

// *** verif/mac_regs_sva.sv ***
`timescale 1ns/1ps
module mac_regs_sva (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // Register bus
    input wire logic [7:0]               address,
    input wire logic                     read,
    input wire logic                     write,
    input wire logic [31:0]              writedata,
    input wire logic [3:0]               byteenable,
    input wire logic [31:0]              readdata,
    input wire logic                     waitrequest,
    // Sources and outputs
    input wire logic                     host_error_pending,
    input wire logic                     stats_pending,
    input wire logic                     mac_misc_irq,
    input wire mac_regs_pkg::rx_filter_t rx_filter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] lanes;
    logic        rd_raw;
    logic        rd_msk;
    logic        done;
    assign lanes = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign rd_raw = read && waitrequest && address == 8'h00;
    assign rd_msk = read && waitrequest && address == 8'h04;
    assign done = write && !waitrequest;
    // Read value is taken from the sources at the edge the request is seen
    property p_raw;
        rd_raw |=> readdata[1:0] == {$past(host_error_pending), $past(stats_pending)};
    endproperty
    a_raw: assert property (p_raw) else $error("raw status bits wrong");
    property p_msk_sub;
        rd_msk |=> (readdata[1:0] & ~{$past(host_error_pending), $past(stats_pending)}) == 2'h0;
    endproperty
    a_msk_sub: assert property (p_msk_sub) else $error("masked bit without source");
    property p_msk_irq;
        rd_msk |=> mac_misc_irq == (|readdata[1:0]);
    endproperty
    a_msk_irq: assert property (p_msk_irq) else $error("irq disagrees with masked");
    property p_rsvd;
        read && waitrequest && address < 8'h10 |=> readdata[31:2] == 30'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_quiet;
        !host_error_pending && !stats_pending |=> !mac_misc_irq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq with no source");
    property p_set;
        done && address == 8'h08 && writedata[1] && byteenable[0] ##1 host_error_pending
            |=> mac_misc_irq;
    endproperty
    a_set: assert property (p_set) else $error("set did not enable");
    property p_clear;
        done && address == 8'h0c && writedata[1:0] == 2'h3 && byteenable[0] |=> ##1 !mac_misc_irq;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not disable");
    property p_filt_rsvd;
        (rx_filter & ~mac_regs_pkg::FILTER_RW_MASK) == 32'h0;
    endproperty
    a_filt_rsvd: assert property (p_filt_rsvd) else $error("filter reserved set");
    property p_filt_wr;
        done && address == 8'h10 |=> rx_filter == ((($past(rx_filter) & ~$past(lanes))
            | ($past(writedata) & $past(lanes))) & mac_regs_pkg::FILTER_RW_MASK);
    endproperty
    a_filt_wr: assert property (p_filt_wr) else $error("filter write wrong");
    c_msk: cover property (rd_msk ##1 mac_misc_irq);
    c_filt: cover property (done && address == 8'h10);
    c_clear: cover property (done && address == 8'h0c && byteenable[0]);
endmodule
bind mac_irq_and_rx_filter_regs mac_regs_sva mac_regs_sva_i (.clk, .rst_n, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .host_error_pending,
    .stats_pending, .mac_misc_irq, .rx_filter);

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic [7:0]               address = 8'h00;
    logic                     read = 1'b0;
    logic                     write = 1'b0;
    logic [31:0]              writedata = 32'h0;
    logic [3:0]               byteenable = 4'hf;
    logic [31:0]              readdata;
    logic                     waitrequest;
    logic                     host_error_pending = 1'b0;
    logic                     stats_pending = 1'b0;
    logic                     mac_misc_irq;
    logic                     event_irq;
    mac_regs_pkg::rx_filter_t rx_filter;
    int                       fail_count = 0;
    int                       checks = 0;
    int                       seed = 32'hd034;
    logic [1:0]               en = 2'h0;
    logic [1:0]               ev = 2'h0;
    logic [1:0]               ev_en = 2'h0;
    logic [31:0]              filt = 32'h0;
    logic [31:0]              got;
    logic [31:0]              r;
    wire logic [1:0]          raw = {host_error_pending, stats_pending};
    always #12.5 clk = ~clk;
    mac_irq_and_rx_filter_regs mac_irq_and_rx_filter_regs_i (.clk, .rst_n, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .host_error_pending,
        .stats_pending, .mac_misc_irq, .event_irq, .rx_filter);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Request held until waitrequest is seen low; bounded so a hang ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !w;
        write <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            fail_count++;
            print_verdict();
        end
        got = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function automatic logic [31:0] model(input logic [7:0] a);
        case (a)
            8'h00: model = {30'h0, raw};
            8'h04: model = {30'h0, raw & en};
            8'h08, 8'h0c: model = {30'h0, en};
            8'h10: model = filt;
            8'h14: model = {30'h0, ev};
            8'h18: model = {30'h0, ev_en};
            default: model = 32'h0;
        endcase
    endfunction
    task automatic rd(input logic [7:0] a);
        logic [31:0] exp;
        exp = model(a);
        bus(1'b0, a, 32'h0, 4'hf);
        chk($sformatf("read %h", a), exp, got);
        if (a == 8'h14) ev = ev & ~exp[1:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        bus(1'b1, a, d, be);
        if (a == 8'h08 && be[0]) en = en | d[1:0];
        if (a == 8'h0c && be[0]) en = en & ~d[1:0];
        if (a == 8'h10) filt = ((filt & ~m) | (d & m)) & mac_regs_pkg::FILTER_RW_MASK;
        if (a == 8'h18 && be[0]) ev_en = d[1:0];
    endtask
    // Sources change only while the bus is idle, so no edge meets a clearing read
    task automatic pend(input logic [1:0] p);
        ev = ev | (p & ~raw);
        @(posedge clk);
        host_error_pending <= p[1];
        stats_pending <= p[0];
        repeat (4) @(posedge clk);
    endtask
    task automatic irqs();
        chk("mac_misc_irq", 32'(|(raw & en)), 32'(mac_misc_irq));
        chk("event_irq", 32'(|(ev & ev_en)), 32'(event_irq));
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 32; a += 4) rd(a[7:0]);
        chk("rx_filter", 32'h0, rx_filter);
        $display("reset values done");
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            wr({4'h0, r[5:4], 2'h0}, $random(seed), r[3:0]);
            pend(r[7:6]);
            irqs();
            for (int a = 0; a < 16; a += 4) rd(a[7:0]);
        end
        pend(2'h3);
        wr(8'h08, 32'h3, 4'h1);
        pend(2'h3);
        irqs();
        wr(8'h0c, 32'h3, 4'h1);
        pend(2'h3);
        irqs();
        $display("enable traffic done");
        wr(8'h10, 32'hffff_ffff, 4'hf);
        rd(8'h10);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            wr(8'h10, $random(seed), r[3:0]);
            rd(8'h10);
            chk("rx_filter", filt, rx_filter);
        end
        $display("filter done");
        wr(8'h18, 32'h0, 4'h1);
        pend(2'h0);
        pend(2'h3);
        irqs();
        wr(8'h18, 32'hffff_ffff, 4'h1);
        pend(2'h3);
        irqs();
        rd(8'h14);
        rd(8'h14);
        pend(2'h1);
        irqs();
        wr(8'h1c, 32'hffff_ffff, 4'hf);
        rd(8'h1c);
        $display("events and unmapped done");
        print_verdict();
    end
endmodule
